/* File: verilog/mtsl_top.sv */
// Implementation choice: register access over APB.
`timescale 1ns/1ps
// Summary of operation
// - select 1 emulates motor motion, no drive
// - virtual resolution code 0..3 gives 13/17/20/23
// - connected real encoder overrides virtual resolution
// - virtual encoder type 0 incremental, 1 absolute
// - command 1 params, 2 turns, 3 alarms
// - below signed minimum limit raises limit alarm
// - above signed maximum limit raises limit alarm
// - limit checks only while limit switch is 1
module mtsl_top
  import mtsl_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [15:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // power cycle notice and encoder side
  input  wire logic        i_power_cycle,
  input  wire logic        i_encoder_present,
  input  wire logic [4:0]  i_real_enc_bits,
  input  wire logic [31:0] i_abs_position,
  input  wire logic [31:0] i_virtual_step,
  // outputs to motion and encoder logic
  output logic             o_motor_drive_en,
  output logic             o_emulate_en,
  output logic [4:0]       o_enc_bits,
  output logic             o_enc_absolute,
  output logic             o_write_motor_params,
  output logic             o_clear_multiturn,
  output logic             o_clear_enc_alarm,
  output logic             o_limit_alarm,
  output logic             o_irq
);

  // ****************************************************************
  // state
  // ****************************************************************
  // one packed record holds every flip-flop of the block; the next
  // state is a full copy, so a field missed in the comb process
  // simply keeps its value instead of inferring a latch
  typedef struct packed {
    logic                 test_sel;     // stored motorless select
    logic [1:0]           venc_res;     // stored resolution code
    logic                 venc_type;    // stored encoder type
    logic [1:0]           abs_cmd;      // last command written
    logic [31:0]          lim_min;      // stored minimum limit
    logic [31:0]          lim_max;      // stored maximum limit
    logic                 lim_sw;       // stored limit switch
    logic                 act_emul;     // active motorless select
    logic [1:0]           act_res;      // active resolution code
    logic                 act_type;     // active encoder type
    logic [31:0]          act_min;      // active minimum limit
    logic [31:0]          act_max;      // active maximum limit
    logic                 act_sw;       // active limit switch
    logic                 loaded;       // power-up latch done
    logic [31:0]          vpos;         // emulated motor position
    logic [31:0]          pos;          // monitored absolute position
    logic [4:0]           enc_bits;     // resolution in use
    logic                 alarm;        // limit alarm level
    logic                 wr_param;     // command pulses
    logic                 clr_turns;
    logic                 clr_alarm;
    logic [MTSL_IRQ_W-1:0] irq_stat;    // sticky events
    logic [MTSL_IRQ_W-1:0] irq_mask;    // event enables
    logic                 irq;          // interrupt level
    logic                 drive_en;     // motor may be energised
    logic                 pready;       // apb answer
    logic                 pslverr;
    logic [31:0]          prdata;
  } mtsl_state_t;

  mtsl_state_t st_r;                    // registered state
  mtsl_state_t st_nxt;                  // next state

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  logic [13:0] idx;                     // register index of access
  logic        setup;                   // apb setup cycle
  logic        wr_take;                 // write takes effect now
  logic        hit;                     // index is mapped
  logic [31:0] rd_val;                  // read mux output
  logic [4:0]  virt_bits;               // virtual resolution bits
  logic [31:0] pos_now;                 // position being checked
  logic        out_lim;                 // position outside window
  logic [MTSL_IRQ_W-1:0] irq_set;       // events this cycle
  logic [MTSL_IRQ_W-1:0] irq_clr;       // write-one-to-clear

  // the low two address bits are ignored: every register is one
  // aligned word, so the index is the byte address over four
  assign idx     = i_paddr[15:2];
  assign setup   = i_psel & ~i_penable;
  // a write lands only at the edge where the access phase sees
  // pready, never in the setup cycle
  assign wr_take = i_psel & i_penable & st_r.pready & i_pwrite;

  // ****************************************************************
  // address decode and read mux
  // ****************************************************************
  // read data is built in the setup cycle and registered, so the
  // access phase always completes with no wait state
  // unmapped indices answer with an error and read as zero; the
  // read-only monitors ignore writes without flagging them
  always_comb begin
    hit    = 1'b1;
    rd_val = 32'h0;
    case (idx)
      MTSL_IDX_TEST_SEL:  rd_val = {31'h0, st_r.test_sel};
      MTSL_IDX_VENC_RES:  rd_val = {30'h0, st_r.venc_res};
      MTSL_IDX_VENC_TYPE: rd_val = {31'h0, st_r.venc_type};
      MTSL_IDX_ABS_CMD:   rd_val = {30'h0, st_r.abs_cmd};
      MTSL_IDX_LIM_MIN:   rd_val = st_r.lim_min;
      MTSL_IDX_LIM_MAX:   rd_val = st_r.lim_max;
      MTSL_IDX_LIM_SW:    rd_val = {31'h0, st_r.lim_sw};
      MTSL_IDX_IRQ_STAT:  rd_val = {30'h0, st_r.irq_stat};
      MTSL_IDX_IRQ_MASK:  rd_val = {30'h0, st_r.irq_mask};
      MTSL_IDX_POS_MON:   rd_val = st_r.pos;
      MTSL_IDX_ACT_STAT: begin
        rd_val[MTSL_ACT_EMUL]  = st_r.act_emul;
        rd_val[MTSL_ACT_ABS]   = st_r.act_type;
        rd_val[MTSL_ACT_LIMSW] = st_r.act_sw;
        rd_val[MTSL_ACT_ALARM] = st_r.alarm;
        rd_val[MTSL_ACT_BITS_LSB +: 5] = st_r.enc_bits;
      end
      default:            hit = 1'b0;  // unmapped: error, reads zero
    endcase
  end

  // ****************************************************************
  // resolution, position and limit window
  // ****************************************************************
  // virtual resolution from the active code
  // the default branch cannot be reached with a two-bit code but
  // keeps the decode total; it falls back to the reset resolution
  always_comb begin
    case (mtsl_res_t'(st_r.act_res))
      MTSL_RES_13: virt_bits = MTSL_BITS_13;
      MTSL_RES_17: virt_bits = MTSL_BITS_17;
      MTSL_RES_20: virt_bits = MTSL_BITS_20;
      MTSL_RES_23: virt_bits = MTSL_BITS_23;
      default:     virt_bits = MTSL_BITS_17;
    endcase
  end

  // while emulating the checked position is the internal one
  // the real position is ignored then, so a wandering or absent
  // encoder cannot trip the limits during a dry run
  assign pos_now = st_r.act_emul ? st_r.vpos : i_abs_position;

  // signed compare against both ends; the max default equals the
  // most negative value, so enabling checks with defaults alarms
  // on any position above it - intended, software must set it
  // switch off means no alarm at all, not a held one
  assign out_lim = st_r.act_sw &
                   (($signed(pos_now) < $signed(st_r.act_min)) |
                    ($signed(pos_now) > $signed(st_r.act_max)));

  // ****************************************************************
  // next state
  // ****************************************************************
  // one process computes the whole next state: bus answer, register
  // writes, power-up reload, motion, limit check and interrupts
  always_comb begin
    st_nxt = st_r;

    // apb answer: ready in the first access cycle
    // read data is zero on writes and on errors
    st_nxt.pready  = setup;
    st_nxt.pslverr = setup & ~hit;
    st_nxt.prdata  = (setup & ~i_pwrite & hit) ? rd_val : 32'h0;

    // command pulses last one cycle
    // a command only pulses its output; the stored code stays
    // readable but is never replayed by later writes
    st_nxt.wr_param  = 1'b0;
    st_nxt.clr_turns = 1'b0;
    st_nxt.clr_alarm = 1'b0;
    irq_clr = '0;

    // register writes
    // narrow fields take the low bits of the write data; the rest
    // is dropped, and reads return zeros above the field
    if (wr_take) begin
      case (idx)
        MTSL_IDX_TEST_SEL:  st_nxt.test_sel  = i_pwdata[0];
        MTSL_IDX_VENC_RES:  st_nxt.venc_res  = i_pwdata[1:0];
        MTSL_IDX_VENC_TYPE: st_nxt.venc_type = i_pwdata[0];
        MTSL_IDX_ABS_CMD: begin
          st_nxt.abs_cmd = i_pwdata[1:0];
          case (i_pwdata[1:0])
            MTSL_CMD_WR_PARAM:  st_nxt.wr_param  = 1'b1;
            MTSL_CMD_CLR_TURNS: st_nxt.clr_turns = 1'b1;
            MTSL_CMD_CLR_ALARM: st_nxt.clr_alarm = 1'b1;
            default:            ;                  // no action
          endcase
        end
        MTSL_IDX_LIM_MIN:   st_nxt.lim_min  = i_pwdata;
        MTSL_IDX_LIM_MAX:   st_nxt.lim_max  = i_pwdata;
        MTSL_IDX_LIM_SW:    st_nxt.lim_sw   = i_pwdata[0];
        MTSL_IDX_IRQ_STAT:  irq_clr = i_pwdata[MTSL_IRQ_W-1:0];
        MTSL_IDX_IRQ_MASK:  st_nxt.irq_mask = i_pwdata[MTSL_IRQ_W-1:0];
        default:            ;                    // read-only or unmapped
      endcase
    end

    // settings reach the logic only once per power-up: stored
    // values are copied at the first edge after reset release and
    // again on a power cycle notice, never on a plain write
    // a notice in the same cycle as a write reloads the value
    // stored before that write
    if (~st_r.loaded | i_power_cycle) begin
      st_nxt.loaded   = 1'b1;
      st_nxt.act_emul = st_r.test_sel;
      st_nxt.act_res  = st_r.venc_res;
      st_nxt.act_type = st_r.venc_type;
      st_nxt.act_min  = st_r.lim_min;
      st_nxt.act_max  = st_r.lim_max;
      st_nxt.act_sw   = st_r.lim_sw;
    end

    // emulated motion integrates the commanded step per cycle
    // the virtual position wraps at 32 bits; a long dry run at a high
    // step rate can roll over and fall back inside the window
    if (st_r.act_emul)
      st_nxt.vpos = st_r.vpos + i_virtual_step;

    st_nxt.pos = pos_now;

    // a real encoder wins over the virtual resolution
    // the presence line is taken as synchronous, like every pin except the asynchronous reset
    st_nxt.enc_bits = i_encoder_present ? i_real_enc_bits
                                        : virt_bits;

    // the alarm is a plain level recomputed every cycle; it drops as
    // soon as the position re-enters the window or checks are off
    st_nxt.alarm = out_lim;

    // motor drive stays off through reset and while emulating; it
    // follows the active copy, so it changes only on a reload
    st_nxt.drive_en = st_nxt.loaded & ~st_nxt.act_emul;

    // events: alarm entry and any accepted command; set beats clear
    // so an entry that meets a late acknowledge in the same cycle
    // is never lost
    irq_set = '0;
    irq_set[MTSL_IRQ_LIMIT] = out_lim & ~st_r.alarm;
    irq_set[MTSL_IRQ_CMD]   = st_nxt.wr_param | st_nxt.clr_turns |
                              st_nxt.clr_alarm;
    st_nxt.irq_stat = (st_r.irq_stat & ~irq_clr) | irq_set;
    st_nxt.irq      = |(st_nxt.irq_stat & st_nxt.irq_mask);
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // reset forces stored settings to their defaults and primes the
  // active copy with the same values, ahead of the first reload
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_r           <= '0;
      st_r.test_sel  <= MTSL_RST_TEST_SEL;
      st_r.venc_res  <= MTSL_RST_VENC_RES;
      st_r.venc_type <= MTSL_RST_VENC_TYPE;
      st_r.abs_cmd   <= MTSL_RST_ABS_CMD;
      st_r.lim_min   <= MTSL_RST_LIM_MIN;
      st_r.lim_max   <= MTSL_RST_LIM_MAX;
      st_r.lim_sw    <= MTSL_RST_LIM_SW;
      st_r.act_res   <= MTSL_RST_VENC_RES;
      st_r.act_min   <= MTSL_RST_LIM_MIN;
      st_r.act_max   <= MTSL_RST_LIM_MAX;
      st_r.enc_bits  <= MTSL_BITS_17;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // outputs, all straight from the state register
  // ****************************************************************
  assign o_prdata             = st_r.prdata;
  assign o_pready             = st_r.pready;
  assign o_pslverr            = st_r.pslverr;
  assign o_emulate_en         = st_r.act_emul;
  assign o_motor_drive_en     = st_r.drive_en;
  assign o_enc_bits           = st_r.enc_bits;
  assign o_enc_absolute       = st_r.act_type;
  assign o_write_motor_params = st_r.wr_param;
  assign o_clear_multiturn    = st_r.clr_turns;
  assign o_clear_enc_alarm    = st_r.clr_alarm;
  assign o_limit_alarm        = st_r.alarm;
  assign o_irq                = st_r.irq;

endmodule : mtsl_top

/* File: verilog/mtsl_pkg.sv */
// ****************************************************************
// register map, field layouts and reset values
// ****************************************************************
package mtsl_pkg;
  // register indices; byte address is four times the index
  localparam logic [13:0] MTSL_IDX_TEST_SEL   = 14'h0730;
  localparam logic [13:0] MTSL_IDX_VENC_RES   = 14'h0731;
  localparam logic [13:0] MTSL_IDX_VENC_TYPE  = 14'h0732;
  localparam logic [13:0] MTSL_IDX_ABS_CMD    = 14'h0792;
  localparam logic [13:0] MTSL_IDX_LIM_MIN    = 14'h079a;
  localparam logic [13:0] MTSL_IDX_LIM_MAX    = 14'h079c;
  localparam logic [13:0] MTSL_IDX_LIM_SW     = 14'h079e;
  localparam logic [13:0] MTSL_IDX_IRQ_STAT   = 14'h07b0;
  localparam logic [13:0] MTSL_IDX_IRQ_MASK   = 14'h07b1;
  localparam logic [13:0] MTSL_IDX_POS_MON    = 14'h07b2;
  localparam logic [13:0] MTSL_IDX_ACT_STAT   = 14'h07b3;

  // reset values
  localparam logic        MTSL_RST_TEST_SEL   = 1'h0;
  localparam logic [1:0]  MTSL_RST_VENC_RES   = 2'h1;
  localparam logic        MTSL_RST_VENC_TYPE  = 1'h0;
  localparam logic [1:0]  MTSL_RST_ABS_CMD    = 2'h0;
  localparam logic [31:0] MTSL_RST_LIM_MIN    = 32'h80000000;
  localparam logic [31:0] MTSL_RST_LIM_MAX    = 32'h80000000;
  localparam logic        MTSL_RST_LIM_SW     = 1'h0;

  // absolute encoder command codes
  localparam logic [1:0]  MTSL_CMD_NONE       = 2'h0;
  localparam logic [1:0]  MTSL_CMD_WR_PARAM   = 2'h1;
  localparam logic [1:0]  MTSL_CMD_CLR_TURNS  = 2'h2;
  localparam logic [1:0]  MTSL_CMD_CLR_ALARM  = 2'h3;

  // interrupt status / mask bit positions
  localparam int          MTSL_IRQ_LIMIT      = 0;
  localparam int          MTSL_IRQ_CMD        = 1;
  localparam int          MTSL_IRQ_W          = 2;

  // active status readback bit positions
  localparam int          MTSL_ACT_EMUL       = 0;
  localparam int          MTSL_ACT_ABS        = 1;
  localparam int          MTSL_ACT_LIMSW      = 2;
  localparam int          MTSL_ACT_ALARM      = 3;
  localparam int          MTSL_ACT_BITS_LSB   = 8;

  // virtual encoder resolution codes
  typedef enum logic [1:0] {
    MTSL_RES_13 = 2'b00,
    MTSL_RES_17 = 2'b01,
    MTSL_RES_20 = 2'b10,
    MTSL_RES_23 = 2'b11
  } mtsl_res_t;

  localparam logic [4:0]  MTSL_BITS_13        = 5'h0d;
  localparam logic [4:0]  MTSL_BITS_17        = 5'h11;
  localparam logic [4:0]  MTSL_BITS_20        = 5'h14;
  localparam logic [4:0]  MTSL_BITS_23        = 5'h17;
endpackage : mtsl_pkg

/* File: testbench/mtsl_assertions.sv */
`timescale 1ns/1ps
// ****************************************************************
// port checks of the motorless test and soft limit block
// ****************************************************************
module mtsl_assertions
  import mtsl_pkg::*;
(
  input wire logic        i_mclk,
  input wire logic        i_rst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [15:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        i_encoder_present,
  input wire logic [4:0]  i_real_enc_bits,
  input wire logic        o_motor_drive_en,
  input wire logic        o_emulate_en,
  input wire logic [4:0]  o_enc_bits,
  input wire logic        o_write_motor_params,
  input wire logic        o_clear_multiturn,
  input wire logic        o_clear_enc_alarm
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // completing write to the command register
  wire cmd_wr = i_psel && i_penable && i_pwrite && o_pready
                && i_paddr[15:2] == MTSL_IDX_ABS_CMD;
  sequence s_setup;
    i_psel && !i_penable;
  endsequence
  sequence s_access;
    i_psel && i_penable && o_pready;
  endsequence
  // a pulse follows exactly the write of its own code
  property p_cmd(pulse, code);
    pulse == $past(cmd_wr && i_pwdata[1:0] == code);
  endproperty
  a_ready_after_setup: assert property (s_setup |=> s_access)
    else $error("no pready after setup");
  a_ready_one_cycle: assert property (o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  a_err_on_unmapped: assert property (o_pready |-> o_pslverr ==
    !(i_paddr[15:2] inside {[14'h0730:14'h0732], 14'h0792, 14'h079a,
      14'h079c, 14'h079e, [14'h07b0:14'h07b3]}))
    else $error("pslverr does not match address map");
  a_emul_no_drive: assert property (
    o_emulate_en |-> !o_motor_drive_en) else $error("drive while emulating");
  a_virtual_res: assert property (
    o_emulate_en && $past(o_emulate_en) && !$past(i_encoder_present) |->
    o_enc_bits inside {5'h0d, 5'h11, 5'h14, 5'h17})
    else $error("bad virtual resolution");
  a_real_res: assert property (
    o_emulate_en && $past(o_emulate_en) && $past(i_encoder_present) |->
    o_enc_bits == $past(i_real_enc_bits)) else $error("real bits ignored");
  a_param_pulse: assert property (p_cmd(o_write_motor_params, 2'h1))
    else $error("parameter write pulse wrong");
  a_turns_pulse: assert property (p_cmd(o_clear_multiturn, 2'h2))
    else $error("turn clear pulse wrong");
  a_alarm_pulse: assert property (p_cmd(o_clear_enc_alarm, 2'h3))
    else $error("alarm clear pulse wrong");
endmodule : mtsl_assertions
bind mtsl_top mtsl_assertions mtsl_assertions_inst (.*);

/* File: testbench/mtsl_encoder_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// encoder on the far side: presence, resolution, position
// ****************************************************************
module mtsl_encoder_model #(
  parameter logic [4:0] REAL_BITS = 5'h18  // plain default resolution
)(
  input  wire logic        i_mclk,
  input  wire logic        i_attach,
  input  wire logic [31:0] i_pos,
  output logic             o_present,
  output logic [4:0]       o_bits,
  output logic [31:0]      o_position
);
  logic [31:0] pos_r = 32'h0;  // last position sent
  // one fresh position per cycle, like a serial encoder frame
  always @(posedge i_mclk) begin
    pos_r <= i_pos;
  end
  // detached lines float: show the inverse rather than a held value
  assign o_present  = i_attach;
  assign o_bits     = i_attach ? REAL_BITS : ~REAL_BITS;
  assign o_position = i_attach ? pos_r : ~pos_r;
endmodule : mtsl_encoder_model

/* File: testbench/test_motorless_test_and_soft_limits.sv */
`timescale 1ns/1ps
// ****************************************************************
// bench with a register and limit model
// ****************************************************************
module test_motorless_test_and_soft_limits;
  import mtsl_pkg::*;
  localparam logic [4:0] REAL = 5'h18;  // fitted encoder resolution
  logic        i_mclk, i_rst, i_psel, i_penable, i_pwrite, err;
  logic        i_power_cycle, pres, attach, e1;
  logic [15:0] i_paddr;
  logic [31:0] i_pwdata, i_virtual_step, pos, load_pos, rd;
  logic [4:0]  rbits;
  logic [2:0]  e3;
  logic [31:0] o_prdata;              // design read data
  logic        o_pready, o_pslverr;   // design bus answer
  logic        o_motor_drive_en, o_emulate_en, o_enc_absolute;
  logic        o_write_motor_params, o_clear_multiturn, o_clear_enc_alarm;
  logic        o_limit_alarm, o_irq;
  logic [4:0]  o_enc_bits;
  logic [31:0] mdl [logic [13:0]];  // expected stored registers
  int          bad_count, n_compared, seed, k;
  logic [13:0] idx_l [7] = '{MTSL_IDX_TEST_SEL, MTSL_IDX_VENC_RES,
    MTSL_IDX_VENC_TYPE, MTSL_IDX_ABS_CMD, MTSL_IDX_LIM_MIN,
    MTSL_IDX_LIM_MAX, MTSL_IDX_LIM_SW};
  mtsl_top mtsl_top_inst (.*, .i_encoder_present(pres),
    .i_real_enc_bits(rbits), .i_abs_position(pos));
  mtsl_encoder_model #(.REAL_BITS(REAL)) mtsl_encoder_model_inst (.i_mclk,
    .i_attach(attach), .i_pos(load_pos), .o_present(pres),
    .o_bits(rbits), .o_position(pos));
  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  task automatic check(input string s, input logic [31:0] v, x);
    n_compared++;
    if (v !== x) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", s, x, v);
    end
  endtask : check
  task automatic conclude();
    $display("compared %0d, mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  // one apb transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [13:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge i_mclk);
    i_psel   <= 1'b1;
    i_pwrite <= w;
    i_paddr  <= {a, 2'b00};
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_pready !== 1'b1 && n < 16);
    rd  = o_prdata;
    err = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
    if (o_pready !== 1'b1) begin
      bad_count++;
      conclude();
    end
  endtask : apb
  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    mdl[a] = d & ((a == MTSL_IDX_LIM_MIN || a == MTSL_IDX_LIM_MAX) ?
      32'hffffffff : (a == MTSL_IDX_VENC_RES || a == MTSL_IDX_ABS_CMD) ?
      32'h3 : 32'h1);
    apb(1'b1, a, d);
  endtask : wr
  task automatic settle(input int n);
    repeat (n) @(posedge i_mclk);
    @(negedge i_mclk);
  endtask : settle
  task automatic pwr();
    @(posedge i_mclk);
    i_power_cycle <= 1'b1;
    @(posedge i_mclk);
    i_power_cycle <= 1'b0;
    settle(1);
  endtask : pwr
  // limit alarm expected from the stored limits and switch
  task automatic lim(input logic [31:0] p);
    @(posedge i_mclk);
    load_pos <= p;
    settle(4);
    e1 = mdl[MTSL_IDX_LIM_SW][0] && ($signed(p) <
      $signed(mdl[MTSL_IDX_LIM_MIN]) || $signed(p) >
      $signed(mdl[MTSL_IDX_LIM_MAX]));
  endtask : lim
  initial begin
    seed = 95028;
    {i_psel, i_penable, i_pwrite, i_power_cycle, attach} = '0;
    {i_paddr, i_pwdata, i_virtual_step, load_pos} = '0;
    i_rst = 1'b1;
    mdl[MTSL_IDX_TEST_SEL] = 32'h0;
    mdl[MTSL_IDX_VENC_RES] = 32'h1;
    mdl[MTSL_IDX_VENC_TYPE] = 32'h0;
    mdl[MTSL_IDX_ABS_CMD] = 32'h0;
    mdl[MTSL_IDX_LIM_MIN] = 32'h80000000;
    mdl[MTSL_IDX_LIM_MAX] = 32'h80000000;
    mdl[MTSL_IDX_LIM_SW] = 32'h0;
    repeat (3) @(posedge i_mclk);
    i_rst <= 1'b0;
    for (k = 0; k < 7; k++) begin
      apb(1'b0, idx_l[k], 32'h0);
      check("reset value", rd, mdl[idx_l[k]]);
      wr(idx_l[k], $random(seed));
      apb(1'b0, idx_l[k], 32'h0);
      check("readback", rd, mdl[idx_l[k]]);
    end
    apb(1'b0, 14'h0100, 32'h0);
    check("unmapped", 32'(err), 32'h1);
    apb(1'b0, MTSL_IDX_ACT_STAT, 32'h0);
    check("held", rd & 32'h7, 32'h0);
    pwr();
    apb(1'b0, MTSL_IDX_ACT_STAT, 32'h0);
    e3 = {mdl[MTSL_IDX_LIM_SW][0], mdl[MTSL_IDX_VENC_TYPE][0],
      mdl[MTSL_IDX_TEST_SEL][0]};
    check("loaded", rd & 32'h7, 32'(e3));
    $display("test registers done");
    wr(MTSL_IDX_TEST_SEL, 32'h1);
    for (k = 0; k < 8; k++) begin
      @(posedge i_mclk);
      attach <= k[2];
      wr(MTSL_IDX_VENC_RES, 32'(k[1:0]));
      wr(MTSL_IDX_VENC_TYPE, 32'(k[0]));
      pwr();
      check("res", 32'(o_enc_bits), k[2] ? 32'(REAL) : k[1:0] == 0 ? 32'h0d
        : k[1:0] == 1 ? 32'h11 : k[1:0] == 2 ? 32'h14 : 32'h17);
      check("type", 32'(o_enc_absolute), 32'(k[0]));
      check("drive", 32'(o_motor_drive_en), 32'h0);
      check("emulate", 32'(o_emulate_en), 32'h1);
    end
    $display("test encoder done");
    for (k = 0; k < 4; k++) begin
      wr(MTSL_IDX_ABS_CMD, 32'(k));
      @(negedge i_mclk);
      e3 = {o_clear_enc_alarm, o_clear_multiturn, o_write_motor_params};
      check("cmd", 32'(e3), k == 0 ? 32'h0 : 32'h1 << (k - 1));
    end
    $display("test commands done");
    @(posedge i_mclk);
    attach <= 1'b1;
    wr(MTSL_IDX_TEST_SEL, 32'h0);
    wr(MTSL_IDX_LIM_MIN, 32'hffffff9c);
    wr(MTSL_IDX_LIM_MAX, 32'h64);
    wr(MTSL_IDX_LIM_SW, 32'h1);
    wr(MTSL_IDX_IRQ_MASK, 32'h1);
    pwr();
    wr(MTSL_IDX_IRQ_STAT, 32'h3);
    lim(32'h0);
    foreach (idx_l[i]) begin
      lim(i == 6 ? $random(seed) : (i[0] ? 32'h65 : 32'hffffff9b));
      check("alarm", 32'(o_limit_alarm), 32'(e1));
      check("irq", 32'(o_irq), 32'(e1));
      wr(MTSL_IDX_IRQ_STAT, 32'h1);
      lim(i[1] ? 32'h64 : 32'hffffff9c);
      check("edge", 32'(o_limit_alarm | o_irq), 32'h0);
    end
    wr(MTSL_IDX_IRQ_MASK, 32'h0);
    lim(32'h65);
    check("masked", 32'(o_irq), 32'h0);
    apb(1'b0, MTSL_IDX_IRQ_STAT, 32'h0);
    check("status", rd & 32'h1, 32'h1);
    wr(MTSL_IDX_LIM_SW, 32'h0);
    check("not yet", 32'(o_limit_alarm), 32'h1);
    pwr();
    lim(32'h65);
    check("switch off", 32'(o_limit_alarm), 32'(e1));
    check("drive on", 32'(o_motor_drive_en), 32'h1);
    $display("test limits done");
    wr(MTSL_IDX_TEST_SEL, 32'h1);
    wr(MTSL_IDX_LIM_SW, 32'h1);
    pwr();
    lim(32'h65);
    check("virtual pos", 32'(o_limit_alarm), 32'h0);
    @(posedge i_mclk);
    i_virtual_step <= 32'h8 + ($random(seed) & 32'h7);
    settle(30);
    check("moved", 32'(o_limit_alarm), 32'h1);
    $display("test emulation done");
    conclude();
  end
endmodule : test_motorless_test_and_soft_limits
